// File: inc/tccu_pkg.sv
// package: register map, field layout and enums of the capture/compare channel
package tccu_pkg;
	localparam logic [11:0] TCCU_CTRL_OFS = 12'h000;
	localparam logic [11:0] TCCU_SRC_OFS = 12'h004;
	localparam logic [11:0] TCCU_VAL_OFS = 12'h008;
	localparam logic [11:0] TCCU_STAT_OFS = 12'h00C;
	localparam logic [11:0] TCCU_TMR_OFS = 12'h010;
	localparam int TCCU_EN_BIT = 7;
	localparam int TCCU_TSEL_BIT = 6;
	localparam int TCCU_ADC_BIT = 5;
	localparam int TCCU_IE_BIT = 4;
	localparam logic [3:0] TCCU_M_OFF = 4'h0;
	localparam logic [3:0] TCCU_M_TOG_CLR = 4'h1;
	localparam logic [3:0] TCCU_M_TOG = 4'h2;
	localparam logic [3:0] TCCU_M_CAP_FALL = 4'h4;
	localparam logic [3:0] TCCU_M_CAP_RISE = 4'h5;
	localparam logic [3:0] TCCU_M_CAP_R4 = 4'h6;
	localparam logic [3:0] TCCU_M_CAP_R16 = 4'h7;
	localparam logic [3:0] TCCU_M_SET = 4'h8;
	localparam logic [3:0] TCCU_M_CLR = 4'h9;
	localparam logic [3:0] TCCU_M_SWI = 4'hA;
	localparam logic [3:0] TCCU_M_TRIG = 4'hB;
	localparam logic [3:0] TCCU_PS4 = 4'h3;
	localparam logic [3:0] TCCU_PS16 = 4'hF;
	localparam logic [7:0] TCCU_CTRL_RST = 8'h00;
	localparam logic [3:0] TCCU_SRC_RST = 4'h0;
	localparam int TCCU_NSRC = 9;
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} tccu_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tccu_apb_rsp_t;
	typedef struct packed {
		logic en;
		logic tsel;
		logic adc_sel;
		logic ie;
		logic [3:0] mode;
	} tccu_ctrl_t;
endpackage : tccu_pkg

// File: design/tccu_edge_det.sv
// capture event detector: synchroniser, edge detect and prescaler
`timescale 1ns/1ps
`default_nettype none
module tccu_edge_det #(
	parameter int PS_W = 4
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic src_in,
	input wire logic [3:0] mode_in,
	input wire logic cap_on_in,
	output logic event_out
);
	import tccu_pkg::*;
	logic sync1_r, sync1_nxt;
	logic sync2_r, sync2_nxt;
	logic prev_r, prev_nxt;
	logic [PS_W-1:0] ps_r, ps_nxt;
	logic event_r, event_nxt;
	logic rise, fall;
	always_comb begin
		sync1_nxt = src_in;
		sync2_nxt = sync1_r;
		prev_nxt = sync2_r;
		rise = sync2_r & ~prev_r; // RULE22
		fall = ~sync2_r & prev_r; // RULE22
		ps_nxt = ps_r;
		event_nxt = 1'b0;
		if (!cap_on_in) begin
			ps_nxt = '0; // RULE10
		end else begin
			unique case (mode_in)
				TCCU_M_CAP_FALL: event_nxt = fall; // RULE2
				TCCU_M_CAP_RISE: event_nxt = rise; // RULE2
				TCCU_M_CAP_R4: begin
					// counter kept across prescale changes, so a switch can fire early
					if (rise) begin
						ps_nxt = ps_r + 1'b1; // RULE11
						event_nxt = (ps_r[1:0] == TCCU_PS4[1:0]); // RULE2
					end
				end
				TCCU_M_CAP_R16: begin
					if (rise) begin
						ps_nxt = ps_r + 1'b1;
						event_nxt = (ps_r == TCCU_PS16[PS_W-1:0]); // RULE2
					end
				end
				default: ps_nxt = '0; // RULE10
			endcase
		end
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
			ps_r <= '0; // RULE10
			event_r <= 1'b0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r <= prev_nxt;
			ps_r <= ps_nxt;
			event_r <= event_nxt;
		end
	end
	assign event_out = event_r;
endmodule : tccu_edge_det
`default_nettype wire

// File: design/tccu_top.sv
// capture/compare channel with APB register access
// Functional notes
// RULE1 - capture event copies selected timer value
// RULE2 - mode picks falling, rising, 4th, 16th
// RULE3 - capture sets flag; only software clears
// RULE4 - new capture overwrites unread value
// RULE5 - four-bit select chooses capture source
// RULE6 - pin output write may cause capture
// RULE7 - timer must be synchronous mode
// RULE8 - timer not clocked from raw oscillator
// RULE9 - mode change may give false flag
// RULE10 - prescaler cleared when off or reset
// RULE11 - prescale switch keeps counter
// RULE12 - capture in sleep needs external timer
// RULE13 - compare value pair with timer continuously
// RULE14 - match toggles, sets, clears or triggers
// RULE15 - match sets flag, optional conversion trigger
// RULE16 - toggle mode needs timer prescale 1:1
// RULE17 - clearing control forces output low; a match edge in the same cycle as the write still toggles, sets or, in software or trigger mode, keeps it
// RULE18 - value change suppresses pending timer reset
// RULE19 - compare in sleep needs running timer
// RULE20 - match in sleep with enable wakes
// RULE21 - software routes and drives output pin
// RULE22 - synchronise source, detect edges by sample
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module tccu_top #(
	parameter int TW = 16
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire tccu_pkg::tccu_apb_req_t apb_req_in,
	output tccu_pkg::tccu_apb_rsp_t apb_rsp_out,
	input wire logic [TW-1:0] reference_timer_count_in,
	input wire logic [TW-1:0] alternate_timer_count_in,
	input wire logic remapped_input_pin_in,
	input wire logic cmp1_out_in,
	input wire logic cmp2_out_in,
	input wire logic numeric_oscillator_output_in,
	input wire logic pin_change_event_in,
	input wire logic [3:0] logic_cell_output_in,
	input wire logic sleep_in,
	input wire logic timer_runs_in_sleep_in,
	output logic channel_out,
	output logic adc_trigger_out,
	output logic timer_reset_out,
	output logic wake_request_out,
	output logic channel_event_flag_out
);
	import tccu_pkg::*;
	tccu_ctrl_t ctrl_r, ctrl_nxt;
	logic [3:0] src_r, src_nxt;
	logic [TW-1:0] val_r, val_nxt;
	logic flag_r, flag_nxt;
	logic out_r, out_nxt;
	logic adc_r, adc_nxt;
	logic trst_r, trst_nxt;
	logic wake_r, wake_nxt;
	logic match_prev_r, match_prev_nxt;
	tccu_apb_rsp_t rsp_r, rsp_nxt;
	logic [TCCU_NSRC-1:0] src_vec;
	logic sel_src;
	logic cap_evt;
	logic cap_on;
	logic cmp_on;
	logic match;
	logic match_edge;
	logic wr;
	logic rd;
	logic val_wr;
	logic [TW-1:0] timer_sel;
	function automatic logic is_capture(input logic [3:0] m);
		is_capture = (m >= TCCU_M_CAP_FALL) && (m <= TCCU_M_CAP_R16);
	endfunction : is_capture
	function automatic logic is_compare(input logic [3:0] m);
		is_compare = (m == TCCU_M_TOG_CLR) || (m == TCCU_M_TOG) || (m >= TCCU_M_SET);
	endfunction : is_compare
	assign src_vec = {logic_cell_output_in, pin_change_event_in, numeric_oscillator_output_in,
		cmp2_out_in, cmp1_out_in, remapped_input_pin_in};
	// remapped_input_pin_in is the pad itself, so a port write shows up here too
	assign sel_src = (src_r < 4'(TCCU_NSRC)) ? src_vec[src_r] : 1'b0; // RULE5 RULE6
	assign cap_on = ctrl_r.en && is_capture(ctrl_r.mode);
	assign cmp_on = ctrl_r.en && is_compare(ctrl_r.mode);
	// timer selection applies in every mode except enabled compare; compare always uses the reference timer
	assign timer_sel = (ctrl_r.tsel && !cmp_on) ? alternate_timer_count_in
		: reference_timer_count_in;
	assign match = cmp_on && (val_r == reference_timer_count_in); // RULE13
	assign match_edge = match && !match_prev_r;
	// a write lands only on the edge that shows pready, so the wait state never writes twice
	assign wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && rsp_r.pready;
	assign rd = apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite;
	assign val_wr = wr && (apb_req_in.paddr == TCCU_VAL_OFS);
	tccu_edge_det #(
		.PS_W(4)
	) u_edge (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.src_in(sel_src),
		.mode_in(ctrl_r.mode),
		.cap_on_in(cap_on),
		.event_out(cap_evt)
	);
	always_comb begin
		ctrl_nxt = ctrl_r;
		src_nxt = src_r;
		val_nxt = val_r;
		flag_nxt = flag_r;
		out_nxt = out_r;
		adc_nxt = 1'b0;
		wake_nxt = 1'b0;
		match_prev_nxt = match;
		trst_nxt = 1'b0;
		rsp_nxt = rsp_r;
		rsp_nxt.pready = 1'b0;
		rsp_nxt.pslverr = 1'b0;
		if (wr) begin
			unique case (apb_req_in.paddr)
				TCCU_CTRL_OFS: ctrl_nxt = tccu_ctrl_t'(apb_req_in.pwdata[7:0]);
				TCCU_SRC_OFS: src_nxt = apb_req_in.pwdata[3:0];
				TCCU_VAL_OFS: val_nxt = apb_req_in.pwdata[TW-1:0];
				TCCU_STAT_OFS: begin
					if (apb_req_in.pwdata[0]) begin
						flag_nxt = 1'b0;
					end
				end
				default: rsp_nxt.pslverr = 1'b0;
			endcase
		end
		if (wr && apb_req_in.paddr == TCCU_CTRL_OFS && apb_req_in.pwdata[7:0] == TCCU_CTRL_RST) begin
			out_nxt = 1'b0; // RULE17
		end
		if (cap_evt && cap_on) begin
			val_nxt = timer_sel; // RULE1 RULE4
			flag_nxt = 1'b1; // RULE3 RULE9
		end
		if (match_edge) begin
			flag_nxt = 1'b1; // RULE15
			adc_nxt = ctrl_r.adc_sel; // RULE15
			unique case (ctrl_r.mode)
				TCCU_M_TOG_CLR, TCCU_M_TOG: out_nxt = ~out_r; // RULE14 RULE16
				TCCU_M_SET: out_nxt = 1'b1; // RULE14
				TCCU_M_CLR: out_nxt = 1'b0; // RULE14
				default: out_nxt = out_r; // RULE14
			endcase
			if (sleep_in && ctrl_r.ie && timer_runs_in_sleep_in) begin
				wake_nxt = 1'b1; // RULE19 RULE20
			end
		end
		// the timer reset follows the trigger edge unless the value moved meanwhile
		if (adc_r && ctrl_r.mode == TCCU_M_TRIG && !val_wr) begin
			trst_nxt = 1'b1; // RULE18
		end
		if (apb_req_in.psel && apb_req_in.penable && !rsp_r.pready) begin
			rsp_nxt.pready = 1'b1;
		end
		if (rd) begin
			unique case (apb_req_in.paddr)
				TCCU_CTRL_OFS: rsp_nxt.prdata = {24'h000000, ctrl_r};
				TCCU_SRC_OFS: rsp_nxt.prdata = {28'h0000000, src_r};
				TCCU_VAL_OFS: rsp_nxt.prdata = {{(32-TW){1'b0}}, val_r};
				TCCU_STAT_OFS: rsp_nxt.prdata = {30'h00000000, out_r, flag_r};
				TCCU_TMR_OFS: rsp_nxt.prdata = {{(32-TW){1'b0}}, timer_sel};
				default: rsp_nxt.prdata = 32'h00000000;
			endcase
		end
	end
	// captures in sleep depend on an externally clocked timer outside this block
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin // RULE12
		if (!rst_n_in) begin
			ctrl_r <= tccu_ctrl_t'(TCCU_CTRL_RST);
			src_r <= TCCU_SRC_RST;
			val_r <= '0;
			flag_r <= 1'b0;
			out_r <= 1'b0;
			adc_r <= 1'b0;
			trst_r <= 1'b0;
			wake_r <= 1'b0;
			match_prev_r <= 1'b0;
			rsp_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			src_r <= src_nxt;
			val_r <= val_nxt;
			flag_r <= flag_nxt;
			out_r <= out_nxt;
			adc_r <= adc_nxt;
			trst_r <= trst_nxt;
			wake_r <= wake_nxt;
			match_prev_r <= match_prev_nxt;
			rsp_r <= rsp_nxt;
		end
	end
	assign apb_rsp_out = rsp_r;
	assign channel_out = out_r;
	assign adc_trigger_out = adc_r;
	assign timer_reset_out = trst_r;
	assign wake_request_out = wake_r;
	assign channel_event_flag_out = flag_r;
endmodule : tccu_top
`default_nettype wire

// File: verification/tccu_top_chk.sv
// checker: timing relations at the channel ports
`timescale 1ns/1ps
`default_nettype none
module tccu_top_chk (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire tccu_pkg::tccu_apb_req_t apb_req_in,
	input wire tccu_pkg::tccu_apb_rsp_t apb_rsp_out,
	input wire logic sleep_in,
	input wire logic timer_runs_in_sleep_in,
	input wire logic channel_out,
	input wire logic adc_trigger_out,
	input wire logic timer_reset_out,
	input wire logic wake_request_out,
	input wire logic channel_event_flag_out
);
	import tccu_pkg::*;
	logic wr;
	logic clr;
	logic ctrl0;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	assign wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && apb_rsp_out.pready;
	assign clr = wr && apb_req_in.paddr == TCCU_STAT_OFS && apb_req_in.pwdata[0];
	assign ctrl0 = wr && apb_req_in.paddr == TCCU_CTRL_OFS && apb_req_in.pwdata[7:0] == 8'h00;
	a_flag_sticky: assert property (
		channel_event_flag_out && !clr |=> channel_event_flag_out) else $error("flag dropped");
	a_adc_flag: assert property (
		adc_trigger_out |-> channel_event_flag_out) else $error("trigger without flag");
	a_adc_once: assert property (
		adc_trigger_out |=> !adc_trigger_out) else $error("trigger repeated");
	a_treset_cause: assert property (
		timer_reset_out |-> $past(channel_event_flag_out)) else $error("stray timer reset");
	a_wake_cause: assert property (
		wake_request_out |-> $past(sleep_in && timer_runs_in_sleep_in)) else $error("stray wake");
	a_wake_flag: assert property (
		wake_request_out |-> channel_event_flag_out) else $error("wake without flag");
	a_out_low: assert property (
		ctrl0 |-> ##[1:2] !channel_out) else $error("output not forced low");
	a_out_cause: assert property (
		$changed(channel_out) |-> channel_event_flag_out || $past(wr)) else $error("stray output");
endmodule : tccu_top_chk
bind tccu_top tccu_top_chk i_chk (.ref_clk_in, .rst_n_in, .apb_req_in, .apb_rsp_out, .sleep_in,
	.timer_runs_in_sleep_in, .channel_out, .adc_trigger_out, .timer_reset_out,
	.wake_request_out, .channel_event_flag_out);
`default_nettype wire

// File: verification/tccu_timer_model.sv
// partner: reference timer that the bench keeps loading from tv every cycle
`timescale 1ns/1ps
`default_nettype none
module tccu_timer_model (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [15:0] value_in,
	output logic [15:0] count_out
);
	// synchronous to the system clock, prescale 1:1, so no async counter hazards
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_out <= 16'h0000;
		end else if (load_in) begin
			count_out <= value_in;
		end else begin
			count_out <= count_out + 16'h0001;
		end
	end
endmodule : tccu_timer_model
`default_nettype wire

// File: verification/tb_tccu_top.sv
// testbench: register access, capture and compare scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_tccu_top;
	import tccu_pkg::*;
	logic clk;
	logic rst_n = 1'b0;
	logic ld = 1'b1;
	logic slp = 1'b0;
	logic trun = 1'b0;
	logic out, adc, trst, wake, flag;
	logic [15:0] tv = 16'h0000;
	logic [15:0] tmr;
	logic [8:0] src = 9'h000;
	logic [31:0] rd;
	tccu_apb_req_t rq = '0;
	tccu_apb_rsp_t rs;
	int n_errors = 0;
	int n_compared = 0;
	int n_adc = 0;
	int n_wake = 0;
	int n_trst = 0;
	tccu_top i_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .apb_req_in(rq), .apb_rsp_out(rs),
		.reference_timer_count_in(tmr), .alternate_timer_count_in(~tmr),
		.remapped_input_pin_in(src[0]), .cmp1_out_in(src[1]), .cmp2_out_in(src[2]),
		.numeric_oscillator_output_in(src[3]), .pin_change_event_in(src[4]),
		.logic_cell_output_in(src[8:5]), .sleep_in(slp), .timer_runs_in_sleep_in(trun),
		.channel_out(out), .adc_trigger_out(adc), .timer_reset_out(trst),
		.wake_request_out(wake), .channel_event_flag_out(flag));
	tccu_timer_model i_tmr (.ref_clk_in(clk), .rst_n_in(rst_n), .load_in(ld), .value_in(tv),
		.count_out(tmr));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		n_adc += int'(adc === 1'b1);
		n_wake += int'(wake === 1'b1);
		n_trst += int'(trst === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one idle edge after release so the next setup never overwrites it in the same step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		rq <= '{a, 1'b1, 1'b0, w, d};
		@(posedge clk);
		rq.penable <= 1'b1;
		do @(posedge clk); while (rs.pready !== 1'b1);
		rd = rs.prdata;
		rq <= '{a, 1'b0, 1'b0, 1'b0, d};
		@(posedge clk);
	endtask : xfer
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk
	task automatic pulse(input int s);
		src[s] <= 1'b1;
		repeat (5) @(posedge clk);
		src[s] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : pulse
	task automatic t_src;
		xfer(1'b1, 12'h020, 32'hFF);
		rdchk(12'h020, 32'h0);
		rdchk(TCCU_CTRL_OFS, 32'h0);
		xfer(1'b1, TCCU_CTRL_OFS, 32'h85);
		for (int s = 0; s < TCCU_NSRC; s++) begin
			tv <= 16'h1111 * 16'(s + 1);
			xfer(1'b1, TCCU_SRC_OFS, 32'(s));
			xfer(1'b1, TCCU_STAT_OFS, 32'h1);
			pulse((s + 1) % TCCU_NSRC);
			rdchk(TCCU_STAT_OFS, 32'h0);
			pulse(s);
			rdchk(TCCU_STAT_OFS, 32'h1);
			rdchk(TCCU_VAL_OFS, 32'(16'h1111 * 16'(s + 1)));
		end
		tv <= 16'hA5A5;
		pulse(8);
		tv <= 16'h5A5A;
		pulse(8);
		rdchk(TCCU_VAL_OFS, 32'h5A5A);
		xfer(1'b1, TCCU_CTRL_OFS, 32'hC5);
		tv <= 16'h1234;
		pulse(8);
		rdchk(TCCU_VAL_OFS, 32'h0000EDCB);
		rdchk(TCCU_TMR_OFS, 32'h0000EDCB);
	endtask : t_src
	task automatic t_pre;
		int k [4] = '{1, 1, 4, 16};
		xfer(1'b1, TCCU_SRC_OFS, 32'h0);
		xfer(1'b1, TCCU_CTRL_OFS, 32'h86);
		pulse(0);
		pulse(0);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, TCCU_CTRL_OFS, 32'h0);
			xfer(1'b1, TCCU_CTRL_OFS, 32'h84 + 32'(i));
			xfer(1'b1, TCCU_STAT_OFS, 32'h1);
			repeat (k[i] - 1) pulse(0);
			rdchk(TCCU_STAT_OFS, 32'h0);
			pulse(0);
			rdchk(TCCU_STAT_OFS, 32'h1);
		end
	endtask : t_pre
	task automatic cmp(input logic [31:0] c, input logic o);
		// move the timer off the match first, so the mode write itself cannot match
		tv <= 16'h0FFF;
		xfer(1'b1, TCCU_CTRL_OFS, c);
		xfer(1'b1, TCCU_STAT_OFS, 32'h1);
		tv <= 16'h1000;
		repeat (4) @(posedge clk);
		rdchk(TCCU_STAT_OFS, {30'h0, o, 1'b1});
		chk(32'(out), 32'(o));
	endtask : cmp
	task automatic t_cmp;
		xfer(1'b1, TCCU_CTRL_OFS, 32'h0);
		xfer(1'b1, TCCU_VAL_OFS, 32'h1000);
		cmp(32'h88, 1'b1);
		cmp(32'h89, 1'b0);
		cmp(32'h82, 1'b1);
		cmp(32'h82, 1'b0);
		cmp(32'h88, 1'b1);
		xfer(1'b1, TCCU_CTRL_OFS, 32'h0);
		rdchk(TCCU_STAT_OFS, 32'h1);
		n_adc = 0;
		cmp(32'hAB, 1'b0);
		chk(32'(n_adc), 32'h1);
		chk(32'(n_trst), 32'h1);
		tv <= 16'h0FFF;
		repeat (2) @(posedge clk);
		// match lands so the value write meets the edge after the trigger
		tv <= 16'h1000;
		xfer(1'b1, TCCU_VAL_OFS, 32'h2000);
		repeat (2) @(posedge clk);
		chk(32'(n_adc), 32'h2);
		chk(32'(n_trst), 32'h1);
		tv <= 16'h0FFF;
		xfer(1'b1, TCCU_VAL_OFS, 32'h1000);
		slp <= 1'b1;
		trun <= 1'b1;
		cmp(32'h9A, 1'b0);
		slp <= 1'b0;
		chk(32'(n_wake), 32'h1);
	endtask : t_cmp
	task automatic final_report;
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_src();
		t_pre();
		t_cmp();
		final_report();
	end
endmodule : tb_tccu_top
`default_nettype wire
